// [core/brcr_dvs_ramp.sv]
`timescale 1ns/1ps
`default_nettype none
module brcr_dvs_ramp (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // control
    input wire logic [4:0] target,
    input wire logic slow,
    input wire logic snap,
    // ramped code
    output logic [4:0] code_r
);
    logic [6:0] cnt_r;
    logic [6:0] period;
    logic step_en;

    assign period = slow ? brcr_pkg::STEP_SLOW_CYC : brcr_pkg::STEP_FAST_CYC;
    assign step_en = (cnt_r == period - 7'd1);

    // step divider; idles at zero when on target so a new move waits a full period
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 7'h00;
        end else if (snap || code_r == target || step_en || cnt_r >= period) begin
            cnt_r <= 7'h00;
        end else begin
            cnt_r <= cnt_r + 7'd1;
        end
    end

    // one code (one voltage step) per period toward target
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            code_r <= 5'h00;
        end else if (snap) begin
            code_r <= target;
        end else if (step_en && code_r < target) begin
            code_r <= code_r + 5'd1;
        end else if (step_en && code_r > target) begin
            code_r <= code_r - 5'd1;
        end
    end

    AST_STEP_SPACING: assert property (@(posedge clock) disable iff (!rst_n)
        ($changed(code_r) && !$past(snap)) |-> ($past(cnt_r) == $past(period) - 7'd1))
        else $error("voltage step taken before its period elapsed");
    AST_STEP_SIZE: assert property (@(posedge clock) disable iff (!rst_n)
        !$past(snap) |-> (code_r == $past(code_r) || code_r == $past(code_r) + 5'd1
                          || code_r == $past(code_r) - 5'd1))
        else $error("voltage code moved by more than one step");
endmodule
`default_nettype wire

// [core/brcr_field_reg.sv]
`timescale 1ns/1ps
`default_nettype none
module brcr_field_reg #(
    parameter logic [7:0] MASK = 8'hff
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // update sources
    input wire logic load,
    input wire logic [7:0] load_data,
    input wire logic wr,
    input wire logic [7:0] wr_data,
    // stored value
    output logic [7:0] value_r
);
    // software write wins over a coinciding otp load
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            value_r <= brcr_pkg::RESET_VALUE;
        end else if (wr) begin
            value_r <= wr_data & MASK;
        end else if (load) begin
            value_r <= load_data & MASK;
        end
    end
endmodule
`default_nettype wire

// [core/brcr_pkg.sv]
package brcr_pkg;
    // register page offsets
    localparam logic [7:0] BUCK_A_CONFIG_OFS = 8'h24;
    localparam logic [7:0] BUCK_B_VOLTAGE_OFS = 8'h2e;
    localparam logic [7:0] BUCK_B_STANDBY_VOLTAGE_OFS = 8'h2f;
    localparam logic [7:0] BUCK_B_SLEEP_VOLTAGE_OFS = 8'h30;
    localparam logic [7:0] BUCK_B_MODE_SELECT_OFS = 8'h31;
    localparam logic [7:0] BUCK_B_CONFIG_OFS = 8'h32;
    localparam logic [7:0] BUCK_C_VOLTAGE_OFS = 8'h35;
    localparam logic [7:0] BUCK_C_STANDBY_VOLTAGE_OFS = 8'h36;

    // register indices inside the bank
    localparam int NUM_REGS = 8;
    localparam int IDX_A_CFG = 0;
    localparam int IDX_B_VOLT = 1;
    localparam int IDX_B_STBY = 2;
    localparam int IDX_B_SLEEP = 3;
    localparam int IDX_B_MODE = 4;
    localparam int IDX_B_CFG = 5;
    localparam int IDX_C_VOLT = 6;
    localparam int IDX_C_STBY = 7;

    // implemented-bit masks; unimplemented bits reset, read and stay zero
    localparam logic [7:0] CFG_MASK = 8'h7d;
    localparam logic [7:0] B_VOLT_MASK = 8'h1f;
    localparam logic [7:0] MODE_MASK = 8'h2f;
    localparam logic [7:0] C_VOLT_MASK = 8'h3f;
    localparam logic [7:0] RESET_VALUE = 8'h00;

    // field positions
    localparam int CFG_STEP_RATE_BIT = 6;
    localparam int CFG_PHASE_LSB = 4;
    localparam int CFG_FREQ_LSB = 2;
    localparam int CFG_ILIM_BIT = 0;
    localparam int MODE_TURNOFF_BIT = 5;
    localparam int MODE_SWITCH_LSB = 0;
    localparam int VCODE_LSB = 0;
    localparam int RANGE_BIT = 5;

    // step timing
    localparam int CLOCK_NS = 40;
    localparam int STEP_FAST_NS = 2000;
    localparam int STEP_SLOW_NS = 4000;
    localparam logic [6:0] STEP_FAST_CYC = 7'(STEP_FAST_NS / CLOCK_NS);
    localparam logic [6:0] STEP_SLOW_CYC = 7'(STEP_SLOW_NS / CLOCK_NS);

    typedef enum logic [1:0] {
        OP_NORMAL,
        OP_STANDBY,
        OP_SLEEP
    } brcr_op_t;

    typedef logic [7:0] brcr_mask_arr_t [NUM_REGS];
    localparam brcr_mask_arr_t REG_MASKS = '{CFG_MASK, B_VOLT_MASK, B_VOLT_MASK, B_VOLT_MASK,
                                             MODE_MASK, CFG_MASK, C_VOLT_MASK, C_VOLT_MASK};
endpackage

// [core/brcr_regs.sv]
// Behaviour
// - config bit 6 picks step rate, one step per 2.0 or 4.0 us.
// - config bits 5:4 give the phase clock selection for the buck.
// - config bits 3:2 give the switching frequency selection for the buck.
// - config bit 0 picks current limit, 0 is 2.75 A, 1 is 2.0 A.
// - second buck config register sits at offset 0x32.
// - every register reads and writes at any time, no lock.
// - reset values of fields are loaded from otp contents.
// - second buck normal voltage code in bits 4:0.
// - second buck standby voltage code in bits 4:0.
// - second buck sleep voltage code in bits 4:0.
// - second buck mode bit 5 picks off or sleep after turn-off.
// - second buck mode bits 3:0 hold the switching mode code.
// - third buck normal voltage code in 4:0, range bit in 5.
`timescale 1ns/1ps
`default_nettype none
module brcr_regs (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register page port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // otp default contents
    input wire logic otp_valid,
    input wire logic [7:0] otp_buck_a_config,
    input wire logic [7:0] otp_buck_b_voltage,
    input wire logic [7:0] otp_buck_b_standby_voltage,
    input wire logic [7:0] otp_buck_b_sleep_voltage,
    input wire logic [7:0] otp_buck_b_mode_select,
    input wire logic [7:0] otp_buck_b_config,
    input wire logic [7:0] otp_buck_c_voltage,
    input wire logic [7:0] otp_buck_c_standby_voltage,
    // device operating state
    input wire brcr_pkg::brcr_op_t op_state,
    // first buck controls
    output logic buck_a_step_rate,
    output logic [1:0] buck_a_phase_sel,
    output logic [1:0] buck_a_freq_sel,
    output logic buck_a_current_limit,
    // second buck controls
    output logic buck_b_step_rate,
    output logic [1:0] buck_b_phase_sel,
    output logic [1:0] buck_b_freq_sel,
    output logic buck_b_current_limit,
    output logic buck_b_turnoff_state,
    output logic [3:0] buck_b_switch_mode,
    output logic [4:0] buck_b_vcode,
    // third buck controls
    output logic [4:0] buck_c_vcode,
    output logic buck_c_range_high,
    // otp defaults taken
    output logic otp_loaded
);
    logic [7:0] regs [brcr_pkg::NUM_REGS];
    logic [7:0] otp_vals [brcr_pkg::NUM_REGS];
    logic [brcr_pkg::NUM_REGS-1:0] wr_sel;
    logic load_pend_r;
    logic otp_load;
    logic snap_r;
    logic [4:0] b_target;
    logic [7:0] c_sel;
    logic [7:0] rdata_nxt;

    // map a page offset to a bank index, or -1 when unmapped
    function automatic int addr_index(input logic [7:0] a);
        unique case (a)
            brcr_pkg::BUCK_A_CONFIG_OFS: addr_index = brcr_pkg::IDX_A_CFG;
            brcr_pkg::BUCK_B_VOLTAGE_OFS: addr_index = brcr_pkg::IDX_B_VOLT;
            brcr_pkg::BUCK_B_STANDBY_VOLTAGE_OFS: addr_index = brcr_pkg::IDX_B_STBY;
            brcr_pkg::BUCK_B_SLEEP_VOLTAGE_OFS: addr_index = brcr_pkg::IDX_B_SLEEP;
            brcr_pkg::BUCK_B_MODE_SELECT_OFS: addr_index = brcr_pkg::IDX_B_MODE;
            brcr_pkg::BUCK_B_CONFIG_OFS: addr_index = brcr_pkg::IDX_B_CFG;
            brcr_pkg::BUCK_C_VOLTAGE_OFS: addr_index = brcr_pkg::IDX_C_VOLT;
            brcr_pkg::BUCK_C_STANDBY_VOLTAGE_OFS: addr_index = brcr_pkg::IDX_C_STBY;
            default: addr_index = -1;
        endcase
    endfunction

    // otp contents in bank order
    assign otp_vals[brcr_pkg::IDX_A_CFG] = otp_buck_a_config;
    assign otp_vals[brcr_pkg::IDX_B_VOLT] = otp_buck_b_voltage;
    assign otp_vals[brcr_pkg::IDX_B_STBY] = otp_buck_b_standby_voltage;
    assign otp_vals[brcr_pkg::IDX_B_SLEEP] = otp_buck_b_sleep_voltage;
    assign otp_vals[brcr_pkg::IDX_B_MODE] = otp_buck_b_mode_select;
    assign otp_vals[brcr_pkg::IDX_B_CFG] = otp_buck_b_config;
    assign otp_vals[brcr_pkg::IDX_C_VOLT] = otp_buck_c_voltage;
    assign otp_vals[brcr_pkg::IDX_C_STBY] = otp_buck_c_standby_voltage;

    // one-shot otp load after reset release; async reset can only take constants
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            load_pend_r <= 1'b1;
        end else if (otp_valid) begin
            load_pend_r <= 1'b0;
        end
    end
    assign otp_load = load_pend_r && otp_valid;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            otp_loaded <= 1'b0;
        end else if (otp_load) begin
            otp_loaded <= 1'b1;
        end
    end

    // snap one cycle after the load: on the load edge the target still comes from the reset values
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            snap_r <= 1'b0;
        end else begin
            snap_r <= otp_load;
        end
    end

    // the bank; writes never gated, masks keep unimplemented bits at zero
    genvar gi;
    generate
        for (gi = 0; gi < brcr_pkg::NUM_REGS; gi++) begin : g_bank
            assign wr_sel[gi] = reg_wr && (addr_index(reg_addr) == gi);
            brcr_field_reg #(
                .MASK(brcr_pkg::REG_MASKS[gi])
            ) u_reg (
                .clock(clock),
                .rst_n(rst_n),
                .load(otp_load),
                .load_data(otp_vals[gi]),
                .wr(wr_sel[gi]),
                .wr_data(reg_wdata),
                .value_r(regs[gi])
            );
        end
    endgenerate

    // read data registered; unmapped offsets read zero
    always_comb begin
        rdata_nxt = reg_rdata;
        if (reg_rd) begin
            rdata_nxt = 8'h00;
            for (int i = 0; i < brcr_pkg::NUM_REGS; i++) begin
                if (addr_index(reg_addr) == i) begin
                    rdata_nxt = regs[i];
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= rdata_nxt;
        end
    end

    // config fields out to the analog side, one flop behind the bank
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            buck_a_step_rate <= 1'b0;
            buck_a_phase_sel <= 2'h0;
            buck_a_freq_sel <= 2'h0;
            buck_a_current_limit <= 1'b0;
            buck_b_step_rate <= 1'b0;
            buck_b_phase_sel <= 2'h0;
            buck_b_freq_sel <= 2'h0;
            buck_b_current_limit <= 1'b0;
        end else begin
            buck_a_step_rate <= regs[brcr_pkg::IDX_A_CFG][brcr_pkg::CFG_STEP_RATE_BIT];
            buck_a_phase_sel <= regs[brcr_pkg::IDX_A_CFG][brcr_pkg::CFG_PHASE_LSB +: 2];
            buck_a_freq_sel <= regs[brcr_pkg::IDX_A_CFG][brcr_pkg::CFG_FREQ_LSB +: 2];
            buck_a_current_limit <= regs[brcr_pkg::IDX_A_CFG][brcr_pkg::CFG_ILIM_BIT];
            buck_b_step_rate <= regs[brcr_pkg::IDX_B_CFG][brcr_pkg::CFG_STEP_RATE_BIT];
            buck_b_phase_sel <= regs[brcr_pkg::IDX_B_CFG][brcr_pkg::CFG_PHASE_LSB +: 2];
            buck_b_freq_sel <= regs[brcr_pkg::IDX_B_CFG][brcr_pkg::CFG_FREQ_LSB +: 2];
            buck_b_current_limit <= regs[brcr_pkg::IDX_B_CFG][brcr_pkg::CFG_ILIM_BIT];
        end
    end

    // mode fields of the second buck
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            buck_b_turnoff_state <= 1'b0;
            buck_b_switch_mode <= 4'h0;
        end else begin
            buck_b_turnoff_state <= regs[brcr_pkg::IDX_B_MODE][brcr_pkg::MODE_TURNOFF_BIT];
            buck_b_switch_mode <= regs[brcr_pkg::IDX_B_MODE][brcr_pkg::MODE_SWITCH_LSB +: 4];
        end
    end

    // pick the code for the present operating state; an illegal state falls back to normal
    always_comb begin
        unique case (op_state)
            brcr_pkg::OP_STANDBY: begin
                b_target = regs[brcr_pkg::IDX_B_STBY][4:0];
                c_sel = regs[brcr_pkg::IDX_C_STBY];
            end
            brcr_pkg::OP_SLEEP: begin
                b_target = regs[brcr_pkg::IDX_B_SLEEP][4:0];
                c_sel = regs[brcr_pkg::IDX_C_STBY];
            end
            default: begin
                b_target = regs[brcr_pkg::IDX_B_VOLT][4:0];
                c_sel = regs[brcr_pkg::IDX_C_VOLT];
            end
        endcase
    end

    // second buck moves to a new code at its programmed step rate
    brcr_dvs_ramp u_b_ramp (
        .clock(clock),
        .rst_n(rst_n),
        .target(b_target),
        .slow(regs[brcr_pkg::IDX_B_CFG][brcr_pkg::CFG_STEP_RATE_BIT]),
        .snap(snap_r),
        .code_r(buck_b_vcode)
    );

    // third buck has no step rate here, so its code follows directly
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            buck_c_vcode <= 5'h00;
            buck_c_range_high <= 1'b0;
        end else begin
            buck_c_vcode <= c_sel[brcr_pkg::VCODE_LSB +: 5];
            buck_c_range_high <= c_sel[brcr_pkg::RANGE_BIT];
        end
    end

    AST_CFG_B_READ: assert property (@(posedge clock) disable iff (!rst_n)
        (reg_rd && !reg_wr && reg_addr == brcr_pkg::BUCK_B_CONFIG_OFS)
        |=> reg_rdata == $past(regs[brcr_pkg::IDX_B_CFG]))
        else $error("second buck config not read back at its offset");
    AST_WRITE_ANYTIME: assert property (@(posedge clock) disable iff (!rst_n)
        (reg_wr && addr_index(reg_addr) >= 0)
        |=> regs[addr_index($past(reg_addr))] == ($past(reg_wdata) & brcr_pkg::REG_MASKS[addr_index($past(reg_addr))]))
        else $error("register write not taken");
    AST_RSVD_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
        (regs[brcr_pkg::IDX_A_CFG][7] == 1'b0 && regs[brcr_pkg::IDX_A_CFG][1] == 1'b0
         && regs[brcr_pkg::IDX_B_CFG][7] == 1'b0 && regs[brcr_pkg::IDX_B_CFG][1] == 1'b0))
        else $error("unimplemented config bit set");
    AST_OTP_LOAD: assert property (@(posedge clock) disable iff (!rst_n)
        (otp_load && !reg_wr) |=> regs[brcr_pkg::IDX_B_CFG] == ($past(otp_buck_b_config) & brcr_pkg::CFG_MASK)
                                  && otp_loaded)
        else $error("otp defaults not loaded");
    AST_ILIM_FOLLOW: assert property (@(posedge clock) disable iff (!rst_n)
        ##1 buck_b_current_limit == $past(regs[brcr_pkg::IDX_B_CFG][0])
        && buck_a_phase_sel == $past(regs[brcr_pkg::IDX_A_CFG][5:4]))
        else $error("config field not forwarded");
    AST_FREQ_FOLLOW: assert property (@(posedge clock) disable iff (!rst_n)
        $changed(regs[brcr_pkg::IDX_B_CFG][3:2]) |=> buck_b_freq_sel == $past(regs[brcr_pkg::IDX_B_CFG][3:2]))
        else $error("frequency select not forwarded");
    AST_MODE_FOLLOW: assert property (@(posedge clock) disable iff (!rst_n)
        (reg_wr && reg_addr == brcr_pkg::BUCK_B_MODE_SELECT_OFS)
        |=> ##1 buck_b_turnoff_state == $past(reg_wdata[5], 2) && buck_b_switch_mode == $past(reg_wdata[3:0], 2))
        else $error("mode fields not forwarded");
    AST_B_SLEEP_TARGET: assert property (@(posedge clock) disable iff (!rst_n)
        (op_state == brcr_pkg::OP_SLEEP) |-> b_target == regs[brcr_pkg::IDX_B_SLEEP][4:0])
        else $error("sleep code not selected");
    AST_B_STBY_TARGET: assert property (@(posedge clock) disable iff (!rst_n)
        (op_state == brcr_pkg::OP_STANDBY) |-> b_target == regs[brcr_pkg::IDX_B_STBY][4:0])
        else $error("standby code not selected");
    AST_B_NORM_TARGET: assert property (@(posedge clock) disable iff (!rst_n)
        (op_state == brcr_pkg::OP_NORMAL) |-> b_target == regs[brcr_pkg::IDX_B_VOLT][4:0])
        else $error("normal code not selected");
    AST_C_FORWARD: assert property (@(posedge clock) disable iff (!rst_n)
        (op_state == brcr_pkg::OP_STANDBY) |=> {buck_c_range_high, buck_c_vcode} == $past(regs[brcr_pkg::IDX_C_STBY][5:0]))
        else $error("third buck standby code not forwarded");
    AST_C_NORMAL: assert property (@(posedge clock) disable iff (!rst_n)
        (op_state == brcr_pkg::OP_NORMAL) |=> {buck_c_range_high, buck_c_vcode} == $past(regs[brcr_pkg::IDX_C_VOLT][5:0]))
        else $error("third buck normal code not forwarded");
    AST_B_SNAP: assert property (@(posedge clock) disable iff (!rst_n)
        snap_r |=> buck_b_vcode == $past(b_target))
        else $error("second buck code not snapped to its otp target");
    AST_C_SLEEP: assert property (@(posedge clock) disable iff (!rst_n)
        (op_state == brcr_pkg::OP_SLEEP) |=> {buck_c_range_high, buck_c_vcode} == $past(regs[brcr_pkg::IDX_C_STBY][5:0]))
        else $error("third buck sleep code not forwarded");
endmodule
`default_nettype wire

// [dv/brcr_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // register page offsets in bank index order
    localparam logic [7:0] OFS [8] = '{brcr_pkg::BUCK_A_CONFIG_OFS, brcr_pkg::BUCK_B_VOLTAGE_OFS,
        brcr_pkg::BUCK_B_STANDBY_VOLTAGE_OFS, brcr_pkg::BUCK_B_SLEEP_VOLTAGE_OFS,
        brcr_pkg::BUCK_B_MODE_SELECT_OFS, brcr_pkg::BUCK_B_CONFIG_OFS,
        brcr_pkg::BUCK_C_VOLTAGE_OFS, brcr_pkg::BUCK_C_STANDBY_VOLTAGE_OFS};
    // one field at a time, plus the unimplemented bits
    localparam logic [7:0] PATS [7] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h01, 8'h82};
    // drive side
    logic clock;
    logic rst_n;
    logic [7:0] reg_addr;
    logic reg_wr;
    logic [7:0] reg_wdata;
    logic reg_rd;
    logic otp_valid;
    logic [7:0] otp_v [8];
    brcr_pkg::brcr_op_t op_state;
    // observed side
    logic [7:0] reg_rdata;
    logic buck_a_step_rate;
    logic [1:0] buck_a_phase_sel;
    logic [1:0] buck_a_freq_sel;
    logic buck_a_current_limit;
    logic buck_b_step_rate;
    logic [1:0] buck_b_phase_sel;
    logic [1:0] buck_b_freq_sel;
    logic buck_b_current_limit;
    logic buck_b_turnoff_state;
    logic [3:0] buck_b_switch_mode;
    logic [4:0] buck_b_vcode;
    logic [4:0] buck_c_vcode;
    logic buck_c_range_high;
    logic otp_loaded;
    int n_mismatch = 0;
    int comparisons = 0;

    brcr_regs brcr_regs_inst (
        .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .otp_valid(otp_valid),
        .otp_buck_a_config(otp_v[0]), .otp_buck_b_voltage(otp_v[1]),
        .otp_buck_b_standby_voltage(otp_v[2]), .otp_buck_b_sleep_voltage(otp_v[3]),
        .otp_buck_b_mode_select(otp_v[4]), .otp_buck_b_config(otp_v[5]),
        .otp_buck_c_voltage(otp_v[6]), .otp_buck_c_standby_voltage(otp_v[7]), .op_state(op_state),
        .buck_a_step_rate(buck_a_step_rate), .buck_a_phase_sel(buck_a_phase_sel),
        .buck_a_freq_sel(buck_a_freq_sel), .buck_a_current_limit(buck_a_current_limit),
        .buck_b_step_rate(buck_b_step_rate), .buck_b_phase_sel(buck_b_phase_sel),
        .buck_b_freq_sel(buck_b_freq_sel), .buck_b_current_limit(buck_b_current_limit),
        .buck_b_turnoff_state(buck_b_turnoff_state), .buck_b_switch_mode(buck_b_switch_mode),
        .buck_b_vcode(buck_b_vcode), .buck_c_vcode(buck_c_vcode), .buck_c_range_high(buck_c_range_high),
        .otp_loaded(otp_loaded)
    );

    // 25 MHz clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic stop_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask

    // strobes are one cycle wide and change only at the falling edge
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask

    // field outputs packed back into register layout
    function automatic logic [7:0] cfg_a_out();
        return {1'b0, buck_a_step_rate, buck_a_phase_sel, buck_a_freq_sel, 1'b0, buck_a_current_limit};
    endfunction

    function automatic logic [7:0] cfg_b_out();
        return {1'b0, buck_b_step_rate, buck_b_phase_sel, buck_b_freq_sel, 1'b0, buck_b_current_limit};
    endfunction

    // registers are reachable before otp defaults arrive
    task automatic test_before_otp;
        logic [7:0] d;
        check(8'(otp_loaded), 8'h00);
        for (int i = 0; i < 8; i++) begin
            reg_read(OFS[i], d);
            check(d, 8'h00);
        end
    endtask

    // otp defaults taken once, masked, and vcode snapped to target
    task automatic test_otp_load;
        logic [7:0] d;
        otp_valid = 1'b1;
        idle(2);
        check(8'(otp_loaded), 8'h01);
        otp_v[7] = 8'h00;
        for (int i = 0; i < 8; i++) begin
            reg_read(OFS[i], d);
            check(d, (i == 7 ? 8'h15 : otp_v[i]) & brcr_pkg::REG_MASKS[i]);
        end
        check(cfg_a_out(), 8'h7d);
        check(8'(buck_b_vcode), 8'h10);
    endtask

    // one code per 50 cycles at the fast rate, per 100 at the slow rate
    task automatic test_ramp;
        op_state = brcr_pkg::OP_STANDBY;
        idle(40);
        check(8'(buck_b_vcode), 8'h10);
        idle(20);
        check(8'(buck_b_vcode), 8'h11);
        idle(50);
        check(8'(buck_b_vcode), 8'h12);
        idle(60);
        check(8'(buck_b_vcode), 8'h12);
        reg_write(OFS[5], 8'h40);
        idle(2);
        op_state = brcr_pkg::OP_SLEEP;
        idle(90);
        check(8'(buck_b_vcode), 8'h12);
        idle(20);
        check(8'(buck_b_vcode), 8'h11);
    endtask

    // config and mode fields reach their outputs two cycles after the write
    task automatic test_fields;
        logic [7:0] d;
        for (int i = 0; i < 7; i++) begin
            reg_write(OFS[0], PATS[i]);
            reg_write(OFS[5], ~PATS[i]);
            idle(1);
            check(cfg_a_out(), PATS[i] & 8'h7d);
            check(cfg_b_out(), ~PATS[i] & 8'h7d);
            reg_read(OFS[5], d);
            check(d, ~PATS[i] & 8'h7d);
        end
        for (int i = 0; i < 16; i++) begin
            d = {2'b11, 1'(i & 1), 1'b1, 4'(i)};
            reg_write(OFS[4], d);
            idle(1);
            check({3'h0, buck_b_turnoff_state, buck_b_switch_mode}, {3'h0, d[5], d[3:0]});
            reg_read(OFS[4], d);
            check(d, {2'b00, 1'(i & 1), 1'b0, 4'(i)});
        end
        // unmapped place: ignored, reads zero, neighbours untouched
        reg_write(8'h33, 8'hff);
        reg_read(8'h33, d);
        check(d, 8'h00);
        reg_read(OFS[5], d);
        check(d, 8'h7d & ~PATS[6]);
    endtask

    // read and write in one cycle: read returns the old value
    task automatic test_rw_same;
        logic [7:0] d;
        reg_write(OFS[6], 8'h01);
        @(negedge clock);
        reg_addr = OFS[6];
        reg_wdata = 8'h3e;
        reg_wr = 1'b1;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        check(reg_rdata, 8'h01);
        reg_read(OFS[6], d);
        check(d, 8'h3e);
    endtask

    // third buck forwards the register of the current state; sleep uses standby
    task automatic test_buck_c;
        logic [7:0] exp;
        for (int i = 0; i < 4; i++) begin
            op_state = brcr_pkg::brcr_op_t'(2'(i));
            idle(2);
            exp = (i == 1 || i == 2) ? 8'h15 : 8'h3e;
            check({2'b00, buck_c_range_high, buck_c_vcode}, exp);
        end
    endtask

    // watchdog: the sequence needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        stop_test();
    end

    initial begin
        rst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
        otp_valid = 1'b0;
        op_state = brcr_pkg::OP_NORMAL;
        otp_v = '{8'hff, 8'hf0, 8'h12, 8'h11, 8'hff, 8'h82, 8'h2a, 8'h15};
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        test_before_otp();
        test_otp_load();
        test_ramp();
        test_fields();
        test_rw_same();
        test_buck_c();
        stop_test();
    end
endmodule
`default_nettype wire
